// file: prd_consts.svh
// offsets, field positions, page codes and reset values of the register map
// assumes inclusion by the package by bare name; the design modules use its macros through the package
`ifndef PRD_CONSTS_SVH
`define PRD_CONSTS_SVH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define PRD_DATA_W 8
`define PRD_OFF_W 4

// -----------------------------------------------------------------
// command byte layout
// -----------------------------------------------------------------
`define PRD_CMD_PAGE_HIGH_BIT 7
`define PRD_CMD_PAGE_LOW_BIT 6
`define PRD_CMD_TX_BIT 2
`define PRD_CMD_RESET 8'h01

// -----------------------------------------------------------------
// page select codes (high bit, low bit)
// -----------------------------------------------------------------
`define PRD_PS_RUN 2'h0
`define PRD_PS_INIT 2'h1
`define PRD_PS_DIAG 2'h2

// -----------------------------------------------------------------
// offsets inside a page
// -----------------------------------------------------------------
`define PRD_OFF_CMD 4'h0
`define PRD_OFF_01 4'h1
`define PRD_OFF_02 4'h2
`define PRD_OFF_03 4'h3
`define PRD_OFF_04 4'h4
`define PRD_OFF_05 4'h5
`define PRD_OFF_06 4'h6
`define PRD_OFF_07 4'h7
`define PRD_OFF_08 4'h8
`define PRD_OFF_09 4'h9
`define PRD_OFF_0A 4'hA
`define PRD_OFF_0B 4'hB
`define PRD_OFF_0C 4'hC
`define PRD_OFF_0D 4'hD
`define PRD_OFF_0E 4'hE
`define PRD_OFF_0F 4'hF
`define PRD_OFF_STATION_FIRST 4'h1
`define PRD_OFF_STATION_LAST 4'h6
`define PRD_OFF_GROUP_FIRST 4'h8

// -----------------------------------------------------------------
// reset values and reserved read value
// -----------------------------------------------------------------
`define PRD_REG_RESET 8'h00
`define PRD_RESERVED_READ 8'h00

`endif

// file: prd_pkg.sv
// types and decode helpers of the paged register decoder
// assumes prd_consts.svh is on the include path
`default_nettype none

package prd_pkg;
`include "prd_consts.svh"

  typedef enum logic [1:0] {
    PRD_PAGE_RUN,
    PRD_PAGE_INIT,
    PRD_PAGE_DIAG,
    PRD_PAGE_LOCKED
  } prd_page_type;

  typedef struct packed {
    logic csS1;
    logic csS2;
    logic rdS1;
    logic rdS2;
    logic wrS1;
    logic wrS2;
    logic [3:0] offS1;
    logic [3:0] offS2;
    logic [7:0] datS1;
    logic [7:0] datS2;
    logic wrActive;
    logic [3:0] wrOff;
    logic [7:0] wrDat;
    logic [7:0] command;
    logic [15:0] localDma;
    logic [7:0] ringStart;
    logic [7:0] ringStop;
    logic [7:0] boundary;
    logic [7:0] txFirstPage;
    logic [15:0] txLength;
    logic [7:0] eventFlags;
    logic [15:0] hostDmaStart;
    logic [15:0] hostDmaCount;
    logic [7:0] rxSetup;
    logic [7:0] txSetup;
    logic [7:0] busDataSetup;
    logic [7:0] eventMask;
    logic [47:0] stationAddr;
    logic [7:0] rxWritePage;
    logic [63:0] groupFilter;
    logic [7:0] hostNextPtr;
    logic [7:0] netNextPtr;
    logic [15:0] addrCounter;
    logic [7:0] dataOut;
    logic dataOe;
  } prd_state_type;

  function automatic prd_page_type pageOf(input logic [7:0] cmd);
    logic [1:0] sel;
    sel = {cmd[`PRD_CMD_PAGE_HIGH_BIT], cmd[`PRD_CMD_PAGE_LOW_BIT]};
    if (sel == `PRD_PS_RUN)
      return PRD_PAGE_RUN;
    else if (sel == `PRD_PS_INIT)
      return PRD_PAGE_INIT;
    else if (sel == `PRD_PS_DIAG)
      return PRD_PAGE_DIAG;
    else
      return PRD_PAGE_LOCKED;
  endfunction

  function automatic logic hit(input prd_page_type pg,
                               input logic [3:0] off,
                               input prd_page_type wantPg,
                               input logic [3:0] wantOff);
    return (pg == wantPg) && (off == wantOff);
  endfunction
endpackage

`default_nettype wire

// file: prd_read_mux.sv
// read-side selector: one byte from page and offset
// assumes all sources are on the same clock; output is combinational
`timescale 1ns/1ps
`default_nettype none

module prd_read_mux
  import prd_pkg::*;
(
  input wire prd_page_type page,
  input wire logic [3:0] offset,
  input wire logic [7:0] command,
  input wire logic [15:0] localDma,
  input wire logic [7:0] ringStart,
  input wire logic [7:0] ringStop,
  input wire logic [7:0] boundary,
  input wire logic [7:0] txFirstPage,
  input wire logic [7:0] txResult,
  input wire logic [7:0] collisionTally,
  input wire logic [7:0] queuePeek,
  input wire logic [7:0] eventFlags,
  input wire logic [15:0] hostDmaView,
  input wire logic [7:0] rxResult,
  input wire logic [7:0] alignTally,
  input wire logic [7:0] crcTally,
  input wire logic [7:0] missedTally,
  input wire logic [7:0] rxSetup,
  input wire logic [7:0] txSetup,
  input wire logic [7:0] busDataSetup,
  input wire logic [7:0] eventMask,
  input wire logic [47:0] stationAddr,
  input wire logic [7:0] rxWritePage,
  input wire logic [63:0] groupFilter,
  input wire logic [7:0] hostNextPtr,
  input wire logic [7:0] netNextPtr,
  input wire logic [15:0] addrCounter,
  output logic [7:0] readByte
);

  logic [3:0] stIdx;
  logic [3:0] gfIdx;

  always_comb
  begin
    stIdx = offset - `PRD_OFF_STATION_FIRST;
    gfIdx = offset - `PRD_OFF_GROUP_FIRST;
    readByte = `PRD_RESERVED_READ;
    if (offset == `PRD_OFF_CMD)
      readByte = command;
    else if (page == PRD_PAGE_RUN)
    begin
      if (offset == `PRD_OFF_01)
        readByte = localDma[7:0];
      else if (offset == `PRD_OFF_02)
        readByte = localDma[15:8];
      else if (offset == `PRD_OFF_03)
        readByte = boundary;
      else if (offset == `PRD_OFF_04)
        readByte = txResult;
      else if (offset == `PRD_OFF_05)
        readByte = collisionTally;
      else if (offset == `PRD_OFF_06)
        readByte = queuePeek;
      else if (offset == `PRD_OFF_07)
        readByte = eventFlags;
      else if (offset == `PRD_OFF_08)
        readByte = hostDmaView[7:0];
      else if (offset == `PRD_OFF_09)
        readByte = hostDmaView[15:8];
      else if (offset == `PRD_OFF_0C)
        readByte = rxResult;
      else if (offset == `PRD_OFF_0D)
        readByte = alignTally;
      else if (offset == `PRD_OFF_0E)
        readByte = crcTally;
      else if (offset == `PRD_OFF_0F)
        readByte = missedTally;
    end
    else if (page == PRD_PAGE_INIT)
    begin
      if (offset <= `PRD_OFF_STATION_LAST)
        readByte = stationAddr[stIdx[2:0]*8 +: 8];
      else if (offset == `PRD_OFF_07)
        readByte = rxWritePage;
      else
        readByte = groupFilter[gfIdx[2:0]*8 +: 8];
    end
    else if (page == PRD_PAGE_DIAG)
    begin
      if (offset == `PRD_OFF_01)
        readByte = ringStart;
      else if (offset == `PRD_OFF_02)
        readByte = ringStop;
      else if (offset == `PRD_OFF_03)
        readByte = hostNextPtr;
      else if (offset == `PRD_OFF_04)
        readByte = txFirstPage;
      else if (offset == `PRD_OFF_05)
        readByte = netNextPtr;
      else if (offset == `PRD_OFF_06)
        readByte = addrCounter[15:8];
      else if (offset == `PRD_OFF_07)
        readByte = addrCounter[7:0];
      else if (offset == `PRD_OFF_0C)
        readByte = rxSetup;
      else if (offset == `PRD_OFF_0D)
        readByte = txSetup;
      else if (offset == `PRD_OFF_0E)
        readByte = busDataSetup;
      else if (offset == `PRD_OFF_0F)
        readByte = eventMask;
    end
  end

endmodule

`default_nettype wire

// file: prd_decoder.sv
// paged register decoder: host pin port, page decode and register store
// assumes host strobes are asynchronous pins; core inputs share clk
`timescale 1ns/1ps
`default_nettype none

module prd_decoder
  import prd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [3:0] registerOffsetIn,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic txDoneIn,
  input wire logic localDmaUpdate,
  input wire logic [15:0] localDmaNext,
  input wire logic [7:0] txResultIn,
  input wire logic [7:0] collisionTallyIn,
  input wire logic [7:0] queuePeekIn,
  input wire logic [7:0] eventSetIn,
  input wire logic [15:0] hostDmaViewIn,
  input wire logic [7:0] rxResultIn,
  input wire logic [7:0] alignTallyIn,
  input wire logic [7:0] crcTallyIn,
  input wire logic [7:0] missedTallyIn,
  output logic [7:0] commandControl,
  output logic [15:0] localDmaAddr,
  output logic [7:0] ringStartPage,
  output logic [7:0] ringStopPage,
  output logic [7:0] ringBoundary,
  output logic [7:0] txFirstPage,
  output logic [15:0] txLength,
  output logic [7:0] eventFlags,
  output logic [15:0] hostDmaStart,
  output logic [15:0] hostDmaCount,
  output logic [7:0] rxSetup,
  output logic [7:0] txSetup,
  output logic [7:0] busDataSetup,
  output logic [7:0] eventEnableMask,
  output logic [47:0] stationAddr,
  output logic [7:0] rxWritePage,
  output logic [63:0] groupFilter,
  output logic [7:0] hostNextPtr,
  output logic [7:0] netNextPtr,
  output logic [15:0] addrCounter
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  prd_state_type q;
  prd_state_type d;
  prd_page_type curPage;
  prd_page_type wrPage;
  logic [7:0] readByte;
  logic commit;
  logic readActive;
  logic [3:0] stIdx;
  logic [3:0] gfIdx;
  logic [7:0] clearMask;

  assign curPage = pageOf(q.command);
  assign wrPage = curPage;

  // -----------------------------------------------------------------
  // read selection
  // -----------------------------------------------------------------
  prd_read_mux readMux (
    .page(curPage),
    .offset(q.offS2),
    .command(q.command),
    .localDma(q.localDma),
    .ringStart(q.ringStart),
    .ringStop(q.ringStop),
    .boundary(q.boundary),
    .txFirstPage(q.txFirstPage),
    .txResult(txResultIn),
    .collisionTally(collisionTallyIn),
    .queuePeek(queuePeekIn),
    .eventFlags(q.eventFlags),
    .hostDmaView(hostDmaViewIn),
    .rxResult(rxResultIn),
    .alignTally(alignTallyIn),
    .crcTally(crcTallyIn),
    .missedTally(missedTallyIn),
    .rxSetup(q.rxSetup),
    .txSetup(q.txSetup),
    .busDataSetup(q.busDataSetup),
    .eventMask(q.eventMask),
    .stationAddr(q.stationAddr),
    .rxWritePage(q.rxWritePage),
    .groupFilter(q.groupFilter),
    .hostNextPtr(q.hostNextPtr),
    .netNextPtr(q.netNextPtr),
    .addrCounter(q.addrCounter),
    .readByte(readByte)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // pins pass two flops; stage one feeds stage two only
    d.csS1 = chipSelectN;
    d.csS2 = q.csS1;
    d.rdS1 = readStrobeN;
    d.rdS2 = q.rdS1;
    d.wrS1 = writeStrobeN;
    d.wrS2 = q.wrS1;
    d.offS1 = registerOffsetIn;
    d.offS2 = q.offS1;
    d.datS1 = dataIn;
    d.datS2 = q.datS1;

    // write commits on the trailing edge, when address and data are stable
    d.wrActive = ~q.csS2 & ~q.wrS2;
    if (d.wrActive)
    begin
      d.wrOff = q.offS2;
      d.wrDat = q.datS2;
    end
    commit = q.wrActive & ~d.wrActive;
    stIdx = q.wrOff - `PRD_OFF_STATION_FIRST;
    gfIdx = q.wrOff - `PRD_OFF_GROUP_FIRST;

    // core side updates before host writes
    if (txDoneIn)
      d.command[`PRD_CMD_TX_BIT] = 1'b0;
    if (localDmaUpdate)
      d.localDma = localDmaNext;

    // event flags: host writes ones to clear; a new event wins
    clearMask = 8'h00;
    if (commit && hit(wrPage, q.wrOff, PRD_PAGE_RUN, `PRD_OFF_07))
      clearMask = q.wrDat;
    d.eventFlags = (q.eventFlags & ~clearMask) | eventSetIn;

    if (commit)
    begin
      if (q.wrOff == `PRD_OFF_CMD)
        d.command = q.wrDat;
      else if (wrPage == PRD_PAGE_RUN)
      begin
        if (q.wrOff == `PRD_OFF_01)
          d.ringStart = q.wrDat;
        else if (q.wrOff == `PRD_OFF_02)
          d.ringStop = q.wrDat;
        else if (q.wrOff == `PRD_OFF_03)
          d.boundary = q.wrDat;
        else if (q.wrOff == `PRD_OFF_04)
          d.txFirstPage = q.wrDat;
        else if (q.wrOff == `PRD_OFF_05)
          d.txLength[7:0] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_06)
          d.txLength[15:8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_08)
          d.hostDmaStart[7:0] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_09)
          d.hostDmaStart[15:8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0A)
          d.hostDmaCount[7:0] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0B)
          d.hostDmaCount[15:8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0C)
          d.rxSetup = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0D)
          d.txSetup = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0E)
          d.busDataSetup = q.wrDat;
        else if (q.wrOff == `PRD_OFF_0F)
          d.eventMask = q.wrDat;
      end
      else if (wrPage == PRD_PAGE_INIT)
      begin
        if (q.wrOff <= `PRD_OFF_STATION_LAST)
          d.stationAddr[stIdx[2:0]*8 +: 8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_07)
          d.rxWritePage = q.wrDat;
        else
          d.groupFilter[gfIdx[2:0]*8 +: 8] = q.wrDat;
      end
      else if (wrPage == PRD_PAGE_DIAG)
      begin
        // diagnostic page writes trust the host to stay out in normal work
        if (q.wrOff == `PRD_OFF_01)
          d.localDma[7:0] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_02)
          d.localDma[15:8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_03)
          d.hostNextPtr = q.wrDat;
        else if (q.wrOff == `PRD_OFF_05)
          d.netNextPtr = q.wrDat;
        else if (q.wrOff == `PRD_OFF_06)
          d.addrCounter[15:8] = q.wrDat;
        else if (q.wrOff == `PRD_OFF_07)
          d.addrCounter[7:0] = q.wrDat;
        // 04 and 08-0F are reserved here: dropped
      end
      // page 3 writes other than command are dropped
    end

    // read data driven while the synced strobe stays low
    readActive = ~q.csS2 & ~q.rdS2;
    d.dataOe = readActive;
    d.dataOut = readActive ? readByte : 8'h00;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      // strobes idle high so no false access is seen after reset
      q.csS1 <= 1'b1;
      q.csS2 <= 1'b1;
      q.rdS1 <= 1'b1;
      q.rdS2 <= 1'b1;
      q.wrS1 <= 1'b1;
      q.wrS2 <= 1'b1;
      q.command <= `PRD_CMD_RESET;
    end
    else
      q <= d;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign dataOut = q.dataOut;
  assign dataOe = q.dataOe;
  assign commandControl = q.command;
  assign localDmaAddr = q.localDma;
  assign ringStartPage = q.ringStart;
  assign ringStopPage = q.ringStop;
  assign ringBoundary = q.boundary;
  assign txFirstPage = q.txFirstPage;
  assign txLength = q.txLength;
  assign eventFlags = q.eventFlags;
  assign hostDmaStart = q.hostDmaStart;
  assign hostDmaCount = q.hostDmaCount;
  assign rxSetup = q.rxSetup;
  assign txSetup = q.txSetup;
  assign busDataSetup = q.busDataSetup;
  assign eventEnableMask = q.eventMask;
  assign stationAddr = q.stationAddr;
  assign rxWritePage = q.rxWritePage;
  assign groupFilter = q.groupFilter;
  assign hostNextPtr = q.hostNextPtr;
  assign netNextPtr = q.netNextPtr;
  assign addrCounter = q.addrCounter;

endmodule

`default_nettype wire

// file: prd_decoder_props.sv
// concurrent checks on the decoder pins, bound into prd_decoder
// assumes one clock clk and asynchronous active-low reset rstn
`timescale 1ns/1ps
`default_nettype none

module prd_decoder_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic chipSelectN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic txDoneIn,
  input wire logic localDmaUpdate,
  input wire logic [15:0] localDmaNext,
  input wire logic [7:0] eventSetIn,
  input wire logic [7:0] commandControl,
  input wire logic [15:0] localDmaAddr,
  input wire logic [7:0] ringStartPage,
  input wire logic [7:0] eventFlags,
  input wire logic [47:0] stationAddr,
  input wire logic [7:0] rxWritePage,
  input wire logic [63:0] groupFilter
);
  // --------------------------------
  // write history
  // --------------------------------
  // writes commit several edges late, so keep a short window
  logic [7:0] wrHist_q;
  logic wrRecent;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      wrHist_q <= 8'h00;
    else
      wrHist_q <= {wrHist_q[6:0], ~(chipSelectN | writeStrobeN)};
  assign wrRecent = |wrHist_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_read_drive: assert property (
    (!chipSelectN && !readStrobeN)[*3] |=> dataOe)
    else $error("read data not driven");
  a_drive_cause: assert property (
    dataOe |-> !$past(readStrobeN, 3) && !$past(chipSelectN, 3))
    else $error("read data driven without a read");
  a_drive_drop: assert property (
    readStrobeN[*4] |-> !dataOe)
    else $error("read data still driven");
  a_idle_zero: assert property (
    !dataOe |-> dataOut == 8'h00)
    else $error("read byte not zero when idle");
  a_cmd_reset: assert property (
    $rose(rstn) |-> commandControl == 8'h01)
    else $error("command byte wrong after reset");
  a_cmd_cause: assert property (
    $changed(commandControl) |->
      wrRecent || $past(txDoneIn) || $past(txDoneIn, 2))
    else $error("command byte changed with no cause");
  a_map_cause: assert property (
    $changed({stationAddr, groupFilter, rxWritePage, ringStartPage})
      |-> wrRecent)
    else $error("register changed with no write");
  a_tx_clear: assert property (
    txDoneIn && !wrRecent |-> ##[1:2] !commandControl[2])
    else $error("transmit bit not cleared");
  a_dma_load: assert property (
    localDmaUpdate && !wrRecent |=> localDmaAddr == $past(localDmaNext))
    else $error("local address not loaded");
  a_event_set: assert property (
    |eventSetIn |=> (eventFlags & $past(eventSetIn)) == $past(eventSetIn))
    else $error("event flag not set");
endmodule

bind prd_decoder prd_decoder_props prd_decoder_props_i (.*);
`default_nettype wire

// file: prd_host_model.sv
// host processor model on the register pins
// assumes one clock; pins change 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

module prd_host_model (
  input wire logic clk,
  output var logic chipSelectN,
  output var logic readStrobeN,
  output var logic writeStrobeN,
  output var logic [3:0] registerOffsetIn,
  output var logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe
);
  initial
  begin
    {chipSelectN, readStrobeN, writeStrobeN} = 3'h7;
    registerOffsetIn = 4'h0;
    dataIn = 8'h00;
  end
  // --------------------------------
  // one access, strobe low 5 edges, high 6
  // --------------------------------
  // page 2 and 3 writes come only from diagnostic scenarios
  task automatic acc(input logic w, input logic [3:0] o,
                     input logic [7:0] di, output logic [7:0] dq);
    @(posedge clk) #1;
    registerOffsetIn = o;
    dataIn = di;
    chipSelectN = 1'b0;
    writeStrobeN = !w;
    readStrobeN = w;
    repeat (5) @(posedge clk);
    // sample once the edge's updates have settled
    #1;
    dq = (dataOe === 1'b1) ? dataOut : 8'hXX;
    {chipSelectN, readStrobeN, writeStrobeN} = 3'h7;
    // released bus shows the inverse, never the last byte
    dataIn = ~di;
    repeat (6) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// file: prd_decoder_tb.sv
// self-checking bench for the paged register decoder
// assumes the host model drives the pins; core views are set here
`timescale 1ns/1ps
`default_nettype none

module prd_decoder_tb;
  logic clk = 1'b0, rstn = 1'b0, txDoneIn = 1'b0, localDmaUpdate = 1'b0;
  logic chipSelectN, readStrobeN, writeStrobeN, dataOe;
  logic [3:0] registerOffsetIn;
  logic [7:0] dataIn, dataOut, d, eventSetIn = 8'h00;
  logic [7:0] txResultIn = 8'hB4, collisionTallyIn = 8'hB5;
  logic [7:0] queuePeekIn = 8'hB6, rxResultIn = 8'hBC, crcTallyIn = 8'hBE;
  logic [7:0] alignTallyIn = 8'hBD, missedTallyIn = 8'hBF;
  logic [15:0] localDmaNext = 16'h0000, hostDmaViewIn = 16'hB9B8;
  logic [7:0] commandControl, ringStartPage, ringStopPage, ringBoundary;
  logic [7:0] txFirstPage, eventFlags, rxSetup, txSetup, busDataSetup;
  logic [7:0] eventEnableMask, rxWritePage, hostNextPtr, netNextPtr;
  logic [15:0] localDmaAddr, txLength, hostDmaStart, hostDmaCount;
  logic [15:0] addrCounter;
  logic [47:0] stationAddr;
  logic [63:0] groupFilter;
  int err_total = 0;
  int total_checks = 0;
  always #12.5 clk = ~clk;
  prd_decoder prd_decoder_i (.*);
  prd_host_model prd_host_model_i (.*);
  // --------------------------------
  // shared helpers
  // --------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] v);
    logic [7:0] u;
    prd_host_model_i.acc(1'b1, o, v, u);
  endtask
  task automatic rd(input logic [3:0] o);
    prd_host_model_i.acc(1'b0, o, 8'h00, d);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    @(posedge clk) #1;
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({commandControl, stationAddr}, 56'h01000000000000);
    rd(4'h0);
    chk(d, 8'h01);
  endtask
  task automatic t_page0();
    logic [3:0] ro [10] = '{1, 2, 4, 5, 6, 8, 9, 10, 12, 15};
    logic [7:0] ex [10] = '{8'h34, 8'h12, 8'hB4, 8'hB5, 8'hB6, 8'hB8,
                            8'hB9, 8'h00, 8'hBC, 8'hBF};
    @(posedge clk) #1;
    localDmaNext = 16'h1234;
    localDmaUpdate = 1'b1;
    @(posedge clk) #1;
    localDmaUpdate = 1'b0;
    wr(4'h1, 8'hA5);
    wr(4'h2, 8'h5A);
    chk({ringStartPage, ringStopPage}, 16'hA55A);
    for (int o = 3; o < 12; o++)
      if (o != 7)
        wr(4'(o), 8'h30 + 8'(o));
    chk({ringBoundary, txFirstPage, txLength}, 32'h33343635);
    chk({hostDmaStart, hostDmaCount}, 32'h39383B3A);
    for (int i = 0; i < 10; i++)
    begin
      rd(ro[i]);
      chk(d, ex[i]);
    end
    for (int i = 0; i < 4; i++)
      wr(4'hC + 4'(i), 8'h11 + 8'(i));
    chk({rxSetup, txSetup, busDataSetup, eventEnableMask}, 32'h11121314);
  endtask
  task automatic t_page1();
    wr(4'h0, 8'h41);
    chk(commandControl, 8'h41);
    for (int o = 1; o < 16; o++)
      wr(4'(o), 8'h20 + 8'(o));
    chk(stationAddr, 48'h262524232221);
    chk(groupFilter, 64'h2F2E2D2C2B2A2928);
    chk({rxWritePage, ringStartPage, rxSetup}, 24'h27A511);
    for (int o = 0; o < 16; o++)
    begin
      rd(4'(o));
      chk(d, (o == 0) ? 8'h41 : 8'h20 + 8'(o));
    end
  endtask
  task automatic t_page2();
    logic [3:0] ro [7] = '{1, 2, 8, 12, 13, 14, 15};
    logic [7:0] ex [7] = '{8'hA5, 8'h5A, 8'h00, 8'h11, 8'h12, 8'h13, 8'h14};
    wr(4'h0, 8'h81);
    for (int i = 0; i < 7; i++)
    begin
      rd(ro[i]);
      chk(d, ex[i]);
    end
    for (int i = 0; i < 5; i++)
      wr((i == 4) ? 4'h4 : 4'hC + 4'(i), 8'hEE);
    wr(4'h1, 8'h66);
    wr(4'h2, 8'h77);
    chk(localDmaAddr, 16'h7766);
    chk({txFirstPage, rxSetup, eventEnableMask}, 24'h341114);
    for (int o = 3; o < 8; o++)
      if (o != 4)
        wr(4'(o), 8'h40 + 8'(o));
    chk({hostNextPtr, netNextPtr, addrCounter}, 32'h43454647);
  endtask
  task automatic t_page3();
    wr(4'h0, 8'hC1);
    rd(4'h0);
    chk(d, 8'hC1);
    wr(4'h5, 8'h99);
    chk({netNextPtr, stationAddr[39:32], txLength}, 32'h45253635);
  endtask
  task automatic t_core();
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h45);
    chk(commandControl, 8'h45);
    // let the write history drain so the clear check is live
    repeat (8) @(posedge clk);
    @(posedge clk) #1;
    txDoneIn = 1'b1;
    eventSetIn = 8'h81;
    @(posedge clk) #1;
    txDoneIn = 1'b0;
    eventSetIn = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk({commandControl, eventFlags}, 16'h4181);
    wr(4'h0, 8'h01);
    wr(4'h7, 8'h01);
    chk({commandControl, eventFlags}, 16'h0180);
  endtask
  initial
  begin
    t_reset();
    t_page0();
    t_page1();
    t_page2();
    t_page3();
    t_core();
    t_reset();
    summarize();
  end
endmodule

`default_nettype wire
